//--- rtl/led_ctrl_pkg.sv
// Shared constants and types of the LED driver control logic
// Notes on behaviour
// - Control input passes a glitch filter of about 300 ns.
// - Shutdown follows only a filtered low held longer than 1 ms.
// - In shutdown the switch stays off with no pulses.
// - Eight consecutive over-voltage cycles switch off and shut down.
// - Fault stays latched until the control input toggles again.
// - Each enable ramps current limit from minimum to maximum over 2 ms.
// - Switching cycles run at a fixed 600 kHz, duty from the loop.
// - LED current target equals measured input duty times 25 mA.
// - Steady high input gives full nominal current per string.
package led_ctrl_pkg;
	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLOCK_HZ                  = 100_000_000;
	localparam int INPUT_GLITCH_FILTER_TIME_NS = 300;
	localparam int GLITCH_CYCLES =
		(INPUT_GLITCH_FILTER_TIME_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
	localparam int SHUTDOWN_LOW_TIME_US       = 1000;
	localparam int SHUTDOWN_CYCLES = SHUTDOWN_LOW_TIME_US * (CLOCK_HZ / 1_000_000);
	localparam int SOFT_START_TIME_US         = 2000;
	localparam int SOFT_START_CYCLES = SOFT_START_TIME_US * (CLOCK_HZ / 1_000_000);
	localparam int SWITCH_FREQ_HZ             = 600_000;
	localparam int SWITCH_PERIOD_CYCLES       = CLOCK_HZ / SWITCH_FREQ_HZ;
	localparam int OVP_CYCLES                 = 8;
	// ------------------------------------------------------------------
	// Levels
	// ------------------------------------------------------------------
	localparam int LEVEL_W                    = 8;
	localparam logic [7:0] LEVEL_FULL         = 8'hFF;
	localparam logic [7:0] LIMIT_MIN          = 8'h00;
	localparam int LED_FULL_CURRENT_UA        = 25_000;
	localparam int DUTY_WINDOW_CYCLES         = 5000; // 20 kHz period
	typedef enum logic [1:0] {SHUTDOWN, SOFT_START, RUNNING} mode_t;
	typedef struct packed {
		logic [7:0] led_string_current; // Target, FF means 25 mA
		logic [7:0] current_limit;      // Switch limit code
		logic       fault;              // Open-LED fault latched
	} status_t;
endpackage

//--- rtl/glitch_filter.sv
// Input glitch filter for the control pin
`timescale 1ns/1ns
module glitch_filter
	import led_ctrl_pkg::*;
#(
	parameter int CYCLES = GLITCH_CYCLES
) (
	input  wire logic clock,
	input  wire logic reset_n,
	input  wire logic raw,
	output logic      filtered
);
	localparam int CW = $clog2(CYCLES + 1);
	logic [CW-1:0] count;

	// pulse width filter
	// Output follows only after the input differs for CYCLES edges
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			count    <= '0;
			filtered <= 1'b0;
		end else if (raw == filtered) begin
			count <= '0;
		end else if (count == CW'(CYCLES - 1)) begin
			count    <= '0;
			filtered <= raw;
		end else begin
			count <= count + 1'b1;
		end
	end
endmodule // glitch_filter

//--- rtl/led_ctrl.sv
// Enable, dimming, soft start and open-LED protection of the LED driver
`timescale 1ns/1ns
module led_ctrl
	import led_ctrl_pkg::*;
#(
	parameter int SHUTDOWN_CNT   = SHUTDOWN_CYCLES,
	parameter int SOFT_START_CNT = SOFT_START_CYCLES,
	parameter int DUTY_WINDOW    = DUTY_WINDOW_CYCLES
) (
	input  wire logic    clock,
	input  wire logic    rst_n,
	input  wire logic    ctrl_in,
	input  wire logic    ovp_above,
	input  wire logic    loop_off,
	output logic         switch_on,
	output logic         cycle_start,
	output logic         shutdown,
	output status_t      status
);
	// ------------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------------
	logic [1:0] rst_sync;
	logic       reset_n;

	// Two stages so release is clean against the clock
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			rst_sync <= 2'b00;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign reset_n = rst_sync[1];

	// ------------------------------------------------------------------
	// Input filtering
	// ------------------------------------------------------------------
	logic ctrl_f;
	logic ctrl_d;
	logic rise;

	glitch_filter #(
		.CYCLES   (GLITCH_CYCLES)
	) u_filter (
		.clock    (clock),
		.reset_n  (reset_n),
		.raw      (ctrl_in),
		.filtered (ctrl_f)
	);

	// Edge detect on the filtered level
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			ctrl_d <= 1'b0;
		else
			ctrl_d <= ctrl_f;
	end
	assign rise = ctrl_f & ~ctrl_d;

	// ------------------------------------------------------------------
	// Low-time counter
	// ------------------------------------------------------------------
	localparam int LW = $clog2(SHUTDOWN_CNT + 2);
	logic [LW-1:0] low_count;
	logic          low_expired;

	// long low detect
	// Saturates one past the limit, so only more than 1 ms counts
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			low_count <= '0;
		else if (ctrl_f)
			low_count <= '0;
		else if (!low_expired)
			low_count <= low_count + 1'b1;
	end
	assign low_expired = (low_count == LW'(SHUTDOWN_CNT + 1));

	// ------------------------------------------------------------------
	// Switching oscillator
	// ------------------------------------------------------------------
	localparam int PW = $clog2(SWITCH_PERIOD_CYCLES);
	logic [PW-1:0] phase;

	// fixed rate cycle
	// Period is rounded down to whole clocks, about 602 kHz
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			phase <= '0;
		else if (phase == PW'(SWITCH_PERIOD_CYCLES - 1))
			phase <= '0;
		else
			phase <= phase + 1'b1;
	end
	assign cycle_start = (phase == '0);

	// ------------------------------------------------------------------
	// Mode control
	// ------------------------------------------------------------------
	mode_t      mode;
	logic       fault;
	logic [3:0] ovp_count;
	logic       ovp_trip;
	localparam int SW = $clog2(SOFT_START_CNT + 1);
	logic [SW-1:0] ss_count;

	// over-voltage run
	// One sample per switching cycle, any clean cycle restarts the run
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			ovp_count <= '0;
		else if (mode == SHUTDOWN)
			ovp_count <= '0;
		else if (cycle_start)
			ovp_count <= ovp_above ? ovp_count + 1'b1 : 4'h0;
	end
	assign ovp_trip = (ovp_count == 4'(OVP_CYCLES)) && (mode != SHUTDOWN);

	// Fault set wins over the clear when both fall together
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			fault <= 1'b0;
		else if (ovp_trip)
			fault <= 1'b1;
		else if (mode == SHUTDOWN && rise)
			fault <= 1'b0;
	end

	// Mode sequence: shutdown, ramp, steady running
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			mode <= SHUTDOWN;
		end else begin
			unique case (mode)
				SHUTDOWN: begin
					if (rise)
						mode <= SOFT_START;
				end
				SOFT_START: begin
					if (ovp_trip || low_expired)
						mode <= SHUTDOWN;
					else if (ss_count == SW'(SOFT_START_CNT - 1))
						mode <= RUNNING;
				end
				RUNNING: begin
					if (ovp_trip || low_expired)
						mode <= SHUTDOWN;
				end
			endcase
		end
	end
	assign shutdown = (mode == SHUTDOWN);

	// ------------------------------------------------------------------
	// Soft start ramp
	// ------------------------------------------------------------------
	// ramp limit over 2 ms
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			ss_count <= '0;
		else if (mode != SOFT_START)
			ss_count <= '0;
		else if (ss_count != SW'(SOFT_START_CNT - 1))
			ss_count <= ss_count + 1'b1;
	end

	// Limit code scales ramp position onto the full code range
	function automatic logic [7:0] scale(input logic [31:0] num,
		input logic [31:0] den);
		logic [39:0] prod;
		prod = 40'(num) * 40'(LEVEL_FULL);
		scale = 8'(prod / 40'(den));
	endfunction

	// ------------------------------------------------------------------
	// Duty measurement
	// ------------------------------------------------------------------
	localparam int DW = $clog2(DUTY_WINDOW + 1);
	logic [DW-1:0] win_count;
	logic [DW-1:0] high_count;
	logic [7:0]    duty;

	// duty times full current
	// Fixed window averages the pin; exactly one 20 kHz period long
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			win_count  <= '0;
			high_count <= '0;
			duty       <= 8'h00;
		end else if (win_count == DW'(DUTY_WINDOW - 1)) begin
			win_count  <= '0;
			high_count <= '0;
			duty       <= scale(32'(high_count) + 32'(ctrl_f),
				32'(DUTY_WINDOW));
		end else begin
			win_count  <= win_count + 1'b1;
			high_count <= high_count + DW'(ctrl_f);
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			status <= '0;
		end else begin
			status.fault <= fault;
			status.led_string_current <= (mode == SHUTDOWN) ? 8'h00 : duty;
			unique case (mode)
				SHUTDOWN:   status.current_limit <= LIMIT_MIN;
				SOFT_START: status.current_limit <=
					scale(32'(ss_count), 32'(SOFT_START_CNT - 1));
				RUNNING:    status.current_limit <= LEVEL_FULL;
			endcase
		end
	end

	// switch off in shutdown
	// Switch is on from cycle start until the loop ends the pulse
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			switch_on <= 1'b0;
		else if (mode == SHUTDOWN || ovp_trip)
			switch_on <= 1'b0;
		else if (cycle_start)
			switch_on <= 1'b1;
		else if (loop_off)
			switch_on <= 1'b0;
	end
endmodule // led_ctrl

//--- tb/led_ctrl_asserts.sv
// Port checker of the LED control block
`timescale 1ns/1ns
module led_ctrl_asserts
	import led_ctrl_pkg::*;
#(
	parameter int SHUTDOWN_CNT   = 200,
	parameter int SOFT_START_CNT = 256,
	parameter int DUTY_WINDOW    = 100
) (
	input wire logic    clock,
	input wire logic    rst_n,
	input wire logic    ctrl_in,
	input wire logic    ovp_above,
	input wire logic    loop_off,
	input wire logic    switch_on,
	input wire logic    cycle_start,
	input wire logic    shutdown,
	input wire status_t status
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Wake from shutdown, and the trip of the fault latch
	sequence wake_s; $fell(shutdown); endsequence
	sequence trip_s; $rose(status.fault); endsequence
	a_glitch_hold: assert property (wake_s |-> $past(ctrl_in, 25))
		else $error("wake without a steady input");
	a_shut_quiet: assert property (
		shutdown && $past(shutdown) |-> !switch_on)
		else $error("switch on in shutdown");
	// Pulses may not come early, so the rise is timed
	a_cycle_rate: assert property (
		$rose(cycle_start) |-> ##166 cycle_start)
		else $error("switching period wrong");
	a_trip_off: assert property (
		trip_s |-> ##[0:1] (shutdown && !switch_on))
		else $error("fault without shutdown");
	a_fault_hold: assert property (
		status.fault && !ctrl_in |=> status.fault)
		else $error("fault cleared without toggle");
	a_wake_clear: assert property (wake_s |=> !status.fault)
		else $error("fault kept on wake");
	a_ramp_full: assert property (
		wake_s ##300 !shutdown |-> status.current_limit == LEVEL_FULL)
		else $error("limit not full after ramp");
	a_low_shut: assert property (
		$rose(shutdown) |-> !$past(ctrl_in, 150) || $past(ovp_above))
		else $error("shutdown after short low");
	a_idle_zero: assert property (
		shutdown && $past(shutdown) |-> status.led_string_current == 8'h00)
		else $error("current target set in shutdown");
endmodule // led_ctrl_asserts

bind led_ctrl led_ctrl_asserts #(.SHUTDOWN_CNT(SHUTDOWN_CNT),
	.SOFT_START_CNT(SOFT_START_CNT), .DUTY_WINDOW(DUTY_WINDOW)) chk (
	.clock(clock), .rst_n(rst_n), .ctrl_in(ctrl_in), .ovp_above(ovp_above),
	.loop_off(loop_off), .switch_on(switch_on), .cycle_start(cycle_start),
	.shutdown(shutdown), .status(status));

//--- tb/host_pwm.sv
// Host model driving PWM dimming on the control input
`timescale 1ns/1ns
module host_pwm (
	input  wire logic        clock,
	input  wire logic [15:0] high_len,
	input  wire logic [15:0] low_len,
	output logic             ctrl = 1'b0
);
	logic [15:0] count = 16'h0000;
	// fixed high and low spans; zero low gives a steady high
	always @(posedge clock) begin
		count <= (count + 16'h0001 >= high_len + low_len) ? 16'h0000
			: count + 16'h0001;
		ctrl  <= (count < high_len);
	end
endmodule // host_pwm

//--- tb/tb.sv
// Self-checking bench of the LED control block
`timescale 1ns/1ns
module tb
	import led_ctrl_pkg::*;
;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic        ovp_above = 1'b0;
	logic        loop_off = 1'b0;
	logic [15:0] high_len = 16'h0000;
	logic [15:0] low_len = 16'h0001;
	logic        ctrl_in, switch_on, cycle_start, shutdown;
	status_t     status;
	logic [7:0]  phase = 8'h00;
	int          fail_count = 0;
	int          compares = 0;
	int          n;
	int          m;
	always #5 clock = ~clock;
	host_pwm host (.clock(clock), .high_len(high_len), .low_len(low_len),
		.ctrl(ctrl_in));
	// Shutdown time must exceed a 50 kHz dimming low span of 1000 clocks
	led_ctrl #(.SHUTDOWN_CNT(1500), .SOFT_START_CNT(256), .DUTY_WINDOW(2000))
	uut (.clock(clock), .rst_n(rst_n), .ctrl_in(ctrl_in),
		.ovp_above(ovp_above), .loop_off(loop_off), .switch_on(switch_on),
		.cycle_start(cycle_start), .shutdown(shutdown), .status(status));
	// Loop ends each on-pulse at a fixed phase of the period
	always @(posedge clock) begin
		phase    <= cycle_start ? 8'h00 : phase + 8'h01;
		loop_off <= (phase == 8'h50);
	end
	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wait_n(input int cycles);
		repeat (cycles) @(posedge clock);
		#1;
	endtask
	task automatic set_pwm(input logic [15:0] hi, input logic [15:0] lo);
		@(posedge clock);
		high_len <= hi;
		low_len  <= lo;
	endtask
	task automatic set_ovp(input logic level);
		@(posedge clock);
		ovp_above <= level;
	endtask
	task automatic end_of_test;
		if (fail_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_wake;
		set_pwm(16'd25, 16'd60000);
		wait_n(60);
		check(shutdown, 1'b1);
		set_pwm(16'd1, 16'd0);
		wait_n(45);
		check(shutdown, 1'b0);
		wait_n(100);
		check(status.current_limit inside {[8'h21:8'hDF]}, 1'b1);
		wait_n(200);
		check(status.current_limit, LEVEL_FULL);
		// A whole duty window of steady high must pass first
		wait_n(4000);
		check(status.led_string_current, 8'hFF);
	endtask
	task automatic t_cycles;
		n = 0;
		m = 0;
		repeat (1660) begin
			wait_n(1);
			n += cycle_start;
			m += switch_on;
		end
		check(n[7:0], 8'd10);
		// Loop model ends each pulse 82 clocks after the switch turns on
		check(8'(m / 10), 8'd82);
	endtask
	task automatic t_dim;
		// 50 kHz at half duty, spans well over the filter time
		set_pwm(16'd1000, 16'd1000);
		wait_n(4500);
		check(status.led_string_current inside {[8'h7A:8'h85]}, 1'b1);
		check(shutdown, 1'b0);
	endtask
	task automatic t_ovp;
		set_pwm(16'd1, 16'd0);
		wait_n(400);
		// At most six samples high, then a clean sample restarts the run
		set_ovp(1'b1);
		wait_n(995);
		set_ovp(1'b0);
		wait_n(200);
		check(status.fault, 1'b0);
		set_ovp(1'b1);
		wait_n(995);
		check(status.fault, 1'b0);
		wait_n(600);
		check({status.fault, shutdown, switch_on}, 3'b110);
		set_ovp(1'b0);
		wait_n(300);
		check(status.fault, 1'b1);
		set_pwm(16'd0, 16'd1);
		wait_n(50);
		set_pwm(16'd1, 16'd0);
		wait_n(45);
		check({status.fault, shutdown}, 2'b00);
	endtask
	task automatic t_off;
		set_pwm(16'd0, 16'd1);
		wait_n(1400);
		check(shutdown, 1'b0);
		wait_n(400);
		check({shutdown, switch_on}, 2'b10);
	endtask
	// Main sequence, with reset held for eight cycles
	initial begin
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		wait_n(4);
		t_wake();
		t_cycles();
		t_dim();
		t_ovp();
		t_off();
		end_of_test();
	end
	// Watchdog well past the expected run of about 16000 cycles
	initial begin
		#(40000 * 10);
		fail_count++;
		end_of_test();
	end
endmodule // tb
